// >>> rtl/cke_map.vh
// Register offsets, field positions, reset values and codes of the clock enable bank.
`ifndef CKE_MAP_VH
`define CKE_MAP_VH

// Serial slave address, seven bits, read/write direction bit appended on the wire.
`define CKE_SLAVE_ADDR 7'h69

// Control byte indexes.
`define CKE_OFS_FREQ_SEL 3'h0
`define CKE_OFS_PROC_EN 3'h1
`define CKE_OFS_PCI_GFX_EN 3'h2
`define CKE_OFS_MEM_EN_LO 3'h3
`define CKE_OFS_MEM_EN_HI 3'h4
`define CKE_OFS_PERIPH_EN 3'h5
`define CKE_OFS_RSVD 3'h6
`define CKE_OFS_LAST 3'h6

// Field positions inside control byte 0.
`define CKE_B0_TRISTATE 0
`define CKE_B0_SW_SELECT 3
`define CKE_B0_CODE_LSB 4
`define CKE_B0_CODE_MSB 6

// Field positions inside control bytes 2 and 5.
`define CKE_B2_PCI_FREE 6
`define CKE_B2_GFX0 5
`define CKE_B5_GFX1 4

// Power-up values; bits of undefined value come up as zero.
`define CKE_RST_B0 8'h00
`define CKE_RST_B1 8'hff
`define CKE_RST_B2 8'h7f
`define CKE_RST_B3 8'hff
`define CKE_RST_B4 8'h0f
`define CKE_RST_B5 8'h13
`define CKE_RST_B6 8'h00
`define CKE_RST_B7 8'h00

// Fixed reference frequency in kHz.
`define CKE_REF_KHZ 18'h037ee

`endif

// >>> rtl/cke_regs.v
// Eight-byte control store with power-up values and a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "cke_map.vh"

module cke_regs
(
  input wire ref_clk, // System clock.
  input wire nrst, // Asynchronous reset, active low.
  input wire wr_en, // Write strobe, one cycle.
  input wire [2:0] wr_idx, // Byte index written.
  input wire [7:0] wr_data, // Byte written.
  input wire [2:0] rd_idx, // Byte index read.
  output reg [7:0] rd_data, // Registered read data.
  output wire [63:0] all_bytes // Every stored byte, byte 0 lowest.
);

  reg [7:0] mem [0:7];
  integer i;

  // Power-up value of each control byte.
  function [7:0] rst_val;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: rst_val = `CKE_RST_B0;
        3'h1: rst_val = `CKE_RST_B1;
        3'h2: rst_val = `CKE_RST_B2;
        3'h3: rst_val = `CKE_RST_B3;
        3'h4: rst_val = `CKE_RST_B4;
        3'h5: rst_val = `CKE_RST_B5;
        3'h6: rst_val = `CKE_RST_B6;
        default: rst_val = `CKE_RST_B7;
      endcase
    end
  endfunction

  // Storage; every bit, reserved or not, keeps what was last written.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        mem[i] <= rst_val(i[2:0]);
      end
      rd_data <= 8'h00;
    end
    else
    begin
      if (wr_en)
      begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
    end
  end

  assign all_bytes = {mem[7], mem[6], mem[5], mem[4],
                      mem[3], mem[2], mem[1], mem[0]};

endmodule

`default_nettype wire

// >>> rtl/cke_gate.v
// Synchronises one clock source and gates a group of outputs glitch-free.
`timescale 1ns/1ps
`default_nettype none

module cke_gate
#(
  parameter W = 4
)
(
  input wire ref_clk, // System clock.
  input wire nrst, // Asynchronous reset, active low.
  input wire src_pin, // Synthesised clock from outside the domain.
  input wire [W-1:0] en_in, // Enable of each output, serial bit and stop.
  output reg [W-1:0] clk_out // Gated outputs.
);

  reg s1;
  reg s2;
  reg s3;
  reg src;
  reg [W-1:0] en_q;

  // Three-stage sampler; the level counts once stages two and three agree.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      src <= 1'b0;
    end
    else
    begin
      s1 <= src_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        src <= s3;
      end
    end
  end

  // Enables load only while the sampled source is low, so no runt pulse.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_q <= {W{1'b0}};
      clk_out <= {W{1'b0}};
    end
    else
    begin
      if (!src)
      begin
        en_q <= en_in;
      end
      clk_out <= {W{src}} & en_q;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/cke_top.v
// Clock enable register bank with its two-wire serial slave and output gating.
// Notes on behaviour
// - Software code picks processor and memory frequency from eight table values.
// - The same code picks PCI and graphics-port frequencies from their tables.
// - Memory runs at processor rate; reference and interrupt clocks stay fixed.
// - Byte 1 bits 3..0 enable processor clocks 3..0; all bits power up one.
// - Byte 2 bit 6 enables the free-running PCI clock; powers up one.
// - Byte 2 bit 5 enables graphics-port clock 0; powers up one.
// - Byte 2 bits 4..0 enable PCI clocks 4..0; power up one.
// - Byte 3 bits 7..0 enable memory clocks 7..0; power up one.
// - Byte 4 bits 3..0 enable memory clocks 11..8; upper bits reserved.
// - Byte 5 bit 4 enables graphics-port clock 1; other high bits reserved.
// - Byte 5 bits 1 and 0 enable reference clocks 1 and 0.
// - Byte 6 is wholly reserved and drives no output.
// - Byte 0 bit 0 set floats every clock output.
// - Byte 0 bit 3 chooses hardware pins or software code bits 6..4.
// - Each output but the interrupt clock needs its serial enable, and processor, graphics and PCI 4..0 also their stop input; the interrupt clock always runs.
`timescale 1ns/1ps
`default_nettype none
`include "cke_map.vh"

module cke_top
(
  input wire ref_clk, // System clock, 200 MHz.
  input wire nrst, // Asynchronous reset, active low.
  input wire ser_clk, // Serial bus clock pin.
  input wire ser_data_in, // Serial bus data pin level.
  output reg ser_data_out, // Serial data drive value, always low.
  output reg ser_data_oe, // Serial data pulled low while high.
  input wire [2:0] hw_freq_sel, // Hardware frequency select pins.
  input wire proc_stop_n, // Stops processor and graphics clocks, low.
  input wire pci_stop_n, // Stops PCI clocks 4..0, not the free-running one, low.
  input wire proc_src, // Processor and memory rate source.
  input wire pci_src, // PCI rate source.
  input wire gfx_src, // Graphics-port rate source.
  input wire xtal_src, // Fixed reference rate source.
  output wire [3:0] processor_clk_out, // Processor clocks 3..0.
  output wire [11:0] memory_clk_out, // Memory clocks 11..0.
  output wire [4:0] pci_bus_clk_out, // PCI clocks 4..0.
  output wire pci_bus_clk_free, // Free-running PCI clock.
  output wire graphics_port_clk0, // Graphics-port clock 0.
  output wire graphics_port_clk1, // Graphics-port clock 1.
  output wire [1:0] xtal_copy_out, // Reference clocks 1..0.
  output wire interrupt_ctrl_clk_out, // Interrupt controller clock.
  output reg clk_out_oe, // High while the clock outputs are driven.
  output reg [2:0] freq_code, // Frequency code in effect.
  output reg [17:0] proc_freq_khz, // Processor rate in kHz.
  output reg [17:0] mem_freq_khz, // Memory rate in kHz.
  output reg [17:0] pci_freq_khz, // PCI rate in kHz.
  output reg [17:0] gfx_freq_khz, // Graphics-port rate in kHz.
  output reg [17:0] xtal_freq_khz // Reference rate in kHz.
);

  // ==========================================================
  // Serial states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_CNT = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_RDATA = 3'h5;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [2:0] idx;
  reg wr_en;
  reg [7:0] wr_data;
  reg [2:0] wr_idx;
  wire [7:0] rd_data;
  wire [63:0] all_bytes;

  // ==========================================================
  // Pin sampling
  reg scl1;
  reg scl2;
  reg scl3;
  reg scl_f;
  reg scl_p;
  reg sda1;
  reg sda2;
  reg sda3;
  reg sda_f;
  reg sda_p;
  reg [2:0] hw1;
  reg [2:0] hw2;
  reg [2:0] hw3;
  reg [2:0] hw_f;
  reg pst1;
  reg pst2;
  reg pst3;
  reg pst_f;
  reg cst1;
  reg cst2;
  reg cst3;
  reg cst_f;

  // Three flops per pin; a change counts when stages two and three agree.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {scl1, scl2, scl3, scl_f, scl_p} <= 5'h1f;
      {sda1, sda2, sda3, sda_f, sda_p} <= 5'h1f;
      {pst1, pst2, pst3, pst_f} <= 4'hf;
      {cst1, cst2, cst3, cst_f} <= 4'hf;
      hw1 <= 3'h0;
      hw2 <= 3'h0;
      hw3 <= 3'h0;
      hw_f <= 3'h0;
    end
    else
    begin
      scl1 <= ser_clk;
      scl2 <= scl1;
      scl3 <= scl2;
      if (scl2 == scl3)
      begin
        scl_f <= scl3;
      end
      scl_p <= scl_f;
      sda1 <= ser_data_in;
      sda2 <= sda1;
      sda3 <= sda2;
      if (sda2 == sda3)
      begin
        sda_f <= sda3;
      end
      sda_p <= sda_f;
      pst1 <= proc_stop_n;
      pst2 <= pst1;
      pst3 <= pst2;
      if (pst2 == pst3)
      begin
        pst_f <= pst3;
      end
      cst1 <= pci_stop_n;
      cst2 <= cst1;
      cst3 <= cst2;
      if (cst2 == cst3)
      begin
        cst_f <= cst3;
      end
      hw1 <= hw_freq_sel;
      hw2 <= hw1;
      hw3 <= hw2;
      if (hw2 == hw3)
      begin
        hw_f <= hw3;
      end
    end
  end

  wire scl_rise = scl_f && !scl_p;
  wire scl_fall = !scl_f && scl_p;
  wire bus_start = scl_f && scl_p && sda_p && !sda_f;
  wire bus_stop = scl_f && scl_p && !sda_p && sda_f;

  // ==========================================================
  // Serial slave
  // Address comes first, then for writes a dummy command and dummy count; bytes run from 0.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 3'h0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      wr_idx <= 3'h0;
      ser_data_out <= 1'b0;
      ser_data_oe <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      ser_data_out <= 1'b0;
      if (bus_stop)
      begin
        state <= ST_IDLE;
        ser_data_oe <= 1'b0;
      end
      else if (bus_start)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        idx <= `CKE_OFS_FREQ_SEL;
        ser_data_oe <= 1'b0;
      end
      else if (state != ST_IDLE && scl_rise)
      begin
        if (bit_cnt < 4'h8)
        begin
          shreg <= {shreg[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (state == ST_RDATA && bit_cnt == 4'h8)
        begin
          // Master acknowledge: low asks for the next byte.
          if (sda_f)
          begin
            state <= ST_IDLE;
          end
          else
          begin
            idx <= idx + 3'h1;
          end
          bit_cnt <= 4'h9;
        end
      end
      else if (state != ST_IDLE && scl_fall)
      begin
        if (state == ST_RDATA)
        begin
          if (bit_cnt < 4'h8)
          begin
            ser_data_oe <= ~rd_data[3'h7 - bit_cnt[2:0]];
          end
          else if (bit_cnt == 4'h8)
          begin
            ser_data_oe <= 1'b0;
          end
          else
          begin
            bit_cnt <= 4'h0;
            ser_data_oe <= ~rd_data[7];
          end
        end
        else if (bit_cnt == 4'h8)
        begin
          if (state == ST_ADDR && shreg[7:1] != `CKE_SLAVE_ADDR)
          begin
            state <= ST_IDLE;
          end
          else
          begin
            ser_data_oe <= 1'b1; // Acknowledge every accepted byte.
            bit_cnt <= 4'h9;
            if (state == ST_WDATA && idx <= `CKE_OFS_LAST)
            begin
              wr_en <= 1'b1;
              wr_idx <= idx;
              wr_data <= shreg;
            end
          end
        end
        else if (bit_cnt == 4'h9)
        begin
          ser_data_oe <= 1'b0;
          bit_cnt <= 4'h0;
          case (state)
            ST_ADDR:
            begin
              if (shreg[0])
              begin
                state <= ST_RDATA;
                ser_data_oe <= ~rd_data[7];
              end
              else
              begin
                state <= ST_CMD;
              end
            end
            ST_CMD: state <= ST_CNT;
            ST_CNT: state <= ST_WDATA;
            ST_WDATA:
            begin
              if (idx != 3'h7)
              begin
                idx <= idx + 3'h1;
              end
            end
            default: state <= ST_IDLE;
          endcase
        end
      end
    end
  end

  cke_regs u_regs
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(idx),
    .rd_data(rd_data),
    .all_bytes(all_bytes)
  );

  // ==========================================================
  // Frequency selection
  wire [7:0] b0 = all_bytes[7:0];
  wire [7:0] b1 = all_bytes[15:8];
  wire [7:0] b2 = all_bytes[23:16];
  wire [7:0] b3 = all_bytes[31:24];
  wire [7:0] b4 = all_bytes[39:32];
  wire [7:0] b5 = all_bytes[47:40];

  // Rate in kHz for a code; sel 0 processor, 1 PCI, 2 graphics port.
  // Eighteen bits, since the top processor rate does not fit in seventeen.
  function [17:0] rate_khz;
    input [2:0] code;
    input [1:0] sel;
    begin
      case ({sel, code})
        5'h00: rate_khz = 18'h1b580;
        5'h01: rate_khz = 18'h104f0;
        5'h02: rate_khz = 18'h1e460;
        5'h03: rate_khz = 18'h124f8;
        5'h04: rate_khz = 18'h208b4;
        5'h05: rate_khz = 18'h14564;
        5'h06: rate_khz = 18'h17412;
        5'h07: rate_khz = 18'h18768;
        5'h08: rate_khz = 18'h091b4;
        5'h09: rate_khz = 18'h08278;
        5'h0a: rate_khz = 18'h07918;
        5'h0b: rate_khz = 18'h0927c;
        5'h0c: rate_khz = 18'h08214;
        5'h0d: rate_khz = 18'h08214;
        5'h0e: rate_khz = 18'h07c06;
        5'h0f: rate_khz = 18'h08278;
        5'h10: rate_khz = 18'h123cc;
        5'h11: rate_khz = 18'h104f0;
        5'h12: rate_khz = 18'h0f230;
        5'h13: rate_khz = 18'h124f8;
        5'h14: rate_khz = 18'h10428;
        5'h15: rate_khz = 18'h10428;
        5'h16: rate_khz = 18'h0f7a8;
        5'h17: rate_khz = 18'h104f0;
        default: rate_khz = 18'h00000;
      endcase
    end
  endfunction

  wire [2:0] next_freq_code = b0[`CKE_B0_SW_SELECT] ?
    b0[`CKE_B0_CODE_MSB:`CKE_B0_CODE_LSB] : hw_f;

  // Rates in effect, plus the output-float control.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      freq_code <= 3'h0;
      proc_freq_khz <= 18'h00000;
      mem_freq_khz <= 18'h00000;
      pci_freq_khz <= 18'h00000;
      gfx_freq_khz <= 18'h00000;
      xtal_freq_khz <= 18'h00000;
      clk_out_oe <= 1'b0;
    end
    else
    begin
      freq_code <= next_freq_code;
      proc_freq_khz <= rate_khz(next_freq_code, 2'h0);
      mem_freq_khz <= rate_khz(next_freq_code, 2'h0);
      pci_freq_khz <= rate_khz(next_freq_code, 2'h1);
      gfx_freq_khz <= rate_khz(next_freq_code, 2'h2);
      xtal_freq_khz <= `CKE_REF_KHZ;
      clk_out_oe <= ~b0[`CKE_B0_TRISTATE];
    end
  end

  // ==========================================================
  // Output gating
  // Processor and graphics groups obey the processor stop; PCI, except the free-running clock, its own.
  wire [5:0] proc_en = {b5[`CKE_B5_GFX1], b2[`CKE_B2_GFX0], b1[3:0]} &
    {6{pst_f}};
  wire [5:0] pci_en = {b2[`CKE_B2_PCI_FREE], b2[4:0] & {5{cst_f}}};
  wire [2:0] xtal_en = {1'b1, b5[1:0]};
  // Byte 6 and the reserved bits feed none of the enables.

  cke_gate #(.W(4)) u_proc
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_pin(proc_src),
    .en_in(proc_en[3:0]),
    .clk_out(processor_clk_out)
  );

  cke_gate #(.W(2)) u_gfx
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_pin(gfx_src),
    .en_in(proc_en[5:4]),
    .clk_out({graphics_port_clk1, graphics_port_clk0})
  );

  cke_gate #(.W(12)) u_mem
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_pin(proc_src),
    .en_in({b4[3:0], b3}),
    .clk_out(memory_clk_out)
  );

  cke_gate #(.W(6)) u_pci
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_pin(pci_src),
    .en_in(pci_en),
    .clk_out({pci_bus_clk_free, pci_bus_clk_out})
  );

  cke_gate #(.W(3)) u_xtal
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_pin(xtal_src),
    .en_in(xtal_en),
    .clk_out({interrupt_ctrl_clk_out, xtal_copy_out})
  );

endmodule

`default_nettype wire

// >>> tb/cke_top_asserts.sv
// Port checks for the clock enable bank.
`timescale 1ns/1ps
`default_nettype none

// ====================
// Checker
module cke_top_asserts
(
  input wire logic ref_clk, // Clock.
  input wire logic nrst, // Reset, low.
  input wire logic ser_clk, // Link clock.
  input wire logic ser_data_out, // Data value.
  input wire logic ser_data_oe, // Data pull.
  input wire logic proc_stop_n, // Stop pin.
  input wire logic pci_stop_n, // Stop pin.
  input wire logic xtal_src, // Source.
  input wire logic [3:0] processor_clk_out, // Outputs.
  input wire logic [4:0] pci_bus_clk_out, // Outputs.
  input wire logic graphics_port_clk0, // Output.
  input wire logic graphics_port_clk1, // Output.
  input wire logic interrupt_ctrl_clk_out, // Output.
  input wire logic [17:0] proc_freq_khz, // Rate.
  input wire logic [17:0] mem_freq_khz, // Rate.
  input wire logic [17:0] xtal_freq_khz // Rate.
);
  logic [4:0] ps_cnt;
  logic [4:0] qs_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Saturating counts of cycles each stop pin has been held low.
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      ps_cnt <= 5'h00;
    else
      ps_cnt <= proc_stop_n ? 5'h00 : ps_cnt + {4'h0, ~&ps_cnt};
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      qs_cnt <= 5'h00;
    else
      qs_cnt <= pci_stop_n ? 5'h00 : qs_cnt + {4'h0, ~&qs_cnt};

  chk_ack_scl_low: assert property ($changed(ser_data_oe) |-> !ser_clk)
    else $error("data drive moved while link clock high");
  chk_drive_low: assert property (ser_data_oe |-> !ser_data_out)
    else $error("data wire driven high");
  chk_proc_stop: assert property (ps_cnt >= 5'h14 |->
    processor_clk_out == 4'h0 && !graphics_port_clk0 && !graphics_port_clk1)
    else $error("processor clocks run while stopped");
  chk_pci_stop: assert property (qs_cnt >= 5'h1c |->
    pci_bus_clk_out == 5'h00) else $error("pci clocks run while stopped");
  chk_no_runt: assert property ($rose(processor_clk_out[0]) |=>
    processor_clk_out[0] [*3]) else $error("shortened high pulse");
  chk_mem_rate: assert property (mem_freq_khz == proc_freq_khz)
    else $error("memory rate differs from processor rate");
  chk_ref_rate: assert property ($past(nrst) |->
    xtal_freq_khz == 18'h037ee) else $error("reference rate wrong");
  chk_intr_clk_run: assert property ($rose(xtal_src) |->
    ##[1:8] interrupt_ctrl_clk_out) else $error("interrupt clock idle");
endmodule

bind cke_top cke_top_asserts u_chk (.ref_clk, .nrst, .ser_clk,
  .ser_data_out, .ser_data_oe, .proc_stop_n, .pci_stop_n, .xtal_src,
  .processor_clk_out, .pci_bus_clk_out, .graphics_port_clk0,
  .graphics_port_clk1, .interrupt_ctrl_clk_out, .proc_freq_khz,
  .mem_freq_khz, .xtal_freq_khz);
`default_nettype wire

// >>> tb/cke_mst.sv
// Serial bus master model standing in for the system chipset.
`timescale 1ns/1ps
`default_nettype none

// ====================
// Master model
module cke_mst
(
  input wire logic ref_clk, // Pacing clock.
  input wire logic sda_w, // Resolved data wire.
  output var logic scl = 1'b1, // Link clock, idle high.
  output var logic sda_m = 1'b1, // Data drive, one releases.
  output var logic rd_valid = 1'b0, // Strobe per byte read.
  output var logic [7:0] rd_byte = 8'h00 // Byte read.
);
  // Waits whole system clock cycles.
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One 125 ns link clock; data moves only while the clock is low.
  task automatic clk_bit(input logic b, output logic s);
    hold(1);
    sda_m <= b;
    hold(12);
    scl <= 1'b1;
    hold(12);
    s = sda_w;
    scl <= 1'b0;
  endtask

  // Start: data falls while the clock is high.
  task automatic start;
    sda_m <= 1'b1;
    scl <= 1'b1;
    hold(12);
    sda_m <= 1'b0;
    hold(12);
    scl <= 1'b0;
  endtask

  // Stop: data rises while the clock is high; the clock then stands still.
  task automatic stop;
    hold(1);
    sda_m <= 1'b0;
    hold(12);
    scl <= 1'b1;
    hold(12);
    sda_m <= 1'b1;
    hold(12);
  endtask

  // Sends a byte most significant bit first and returns the ack level.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask

  // Reads a byte, acks it unless last, and strobes it out.
  task automatic rd(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
    rd_byte <= d;
    rd_valid <= 1'b1;
    hold(1);
    rd_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/cke_top_tb.sv
// Self-checking bench for the clock enable bank.
`timescale 1ns/1ps
`default_nettype none
`include "cke_map.vh"

// ====================
// Bench top
module cke_top_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] hw_freq_sel = 3'h0;
  logic proc_stop_n = 1'b1;
  logic pci_stop_n = 1'b1;
  logic [7:0] sc = 8'h00;
  logic [7:0] regv [7];
  logic [7:0] exp_q [$];
  int err_total = 0;
  int n_tests = 0;
  wire logic scl, sda_m, rd_valid, ser_data_out, ser_data_oe, clk_out_oe;
  wire logic pci_bus_clk_free, graphics_port_clk0, graphics_port_clk1;
  wire logic interrupt_ctrl_clk_out;
  wire logic [7:0] rd_byte;
  wire logic [3:0] processor_clk_out;
  wire logic [11:0] memory_clk_out;
  wire logic [4:0] pci_bus_clk_out;
  wire logic [1:0] xtal_copy_out;
  wire logic [2:0] freq_code;
  wire logic [17:0] proc_freq_khz, mem_freq_khz, pci_freq_khz;
  wire logic [17:0] gfx_freq_khz, xtal_freq_khz;
  // Open-drain data wire: low if either party pulls it.
  wire logic sda_w = sda_m & ~(ser_data_oe & ~ser_data_out);
  wire logic [25:0] outs = {processor_clk_out, memory_clk_out,
    pci_bus_clk_out, pci_bus_clk_free, graphics_port_clk0,
    graphics_port_clk1, xtal_copy_out};
  // Rates in kHz per code.
  logic [17:0] cpu_t [8] = '{18'h1b580, 18'h104f0, 18'h1e460, 18'h124f8,
    18'h208b4, 18'h14564, 18'h17412, 18'h18768};
  logic [17:0] pci_t [8] = '{18'h091b4, 18'h08278, 18'h07918, 18'h0927c,
    18'h08214, 18'h08214, 18'h07c06, 18'h08278};
  logic [17:0] gfx_t [8] = '{18'h123cc, 18'h104f0, 18'h0f230, 18'h124f8,
    18'h10428, 18'h10428, 18'h0f7a8, 18'h104f0};

  cke_top DUT (.ref_clk, .nrst, .ser_clk(scl), .ser_data_in(sda_w),
    .ser_data_out, .ser_data_oe, .hw_freq_sel, .proc_stop_n, .pci_stop_n,
    .proc_src(sc[2]), .pci_src(sc[3]), .gfx_src(sc[1]), .xtal_src(sc[3]),
    .processor_clk_out, .memory_clk_out, .pci_bus_clk_out,
    .pci_bus_clk_free, .graphics_port_clk0, .graphics_port_clk1,
    .xtal_copy_out, .interrupt_ctrl_clk_out, .clk_out_oe, .freq_code,
    .proc_freq_khz, .mem_freq_khz, .pci_freq_khz, .gfx_freq_khz,
    .xtal_freq_khz);
  cke_mst mst (.ref_clk, .sda_w, .scl, .sda_m, .rd_valid, .rd_byte);

  // 200 MHz clock.
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Synthesiser sources, restarting low at each reset release.
  always @(posedge ref_clk)
    sc <= nrst ? sc + 8'h01 : 8'h00;

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (exp_q.size() != 0)
      err_total++;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each byte read back is matched against the oldest expectation.
  always @(posedge ref_clk)
  begin
    if (rd_valid === 1'b1)
      check("read byte", 32'(rd_byte), 32'(exp_q.pop_front()));
  end

  // Address byte of a frame, write or read.
  task automatic frame_start(input logic rw);
    logic a;
    mst.start();
    mst.wr({`CKE_SLAVE_ADDR, rw}, a);
    check("address ack", 32'(a), 32'h0);
  endtask

  // Dummy command and count, then bytes from index zero.
  task automatic wr_regs(input int n);
    logic a;
    frame_start(1'b0);
    for (int i = -2; i < n; i++)
    begin
      mst.wr(i < 0 ? 8'h00 : regv[i], a);
      check("byte ack", 32'(a), 32'h0);
    end
    mst.stop();
  endtask

  task automatic rd_regs;
    frame_start(1'b1);
    for (int i = 0; i < 7; i++)
    begin
      exp_q.push_back(regv[i]);
      mst.rd(i == 6);
    end
    mst.stop();
  endtask

  // Expected running outputs from the stored enables and the stop pins.
  function automatic logic [25:0] exp_outs(input logic ps, input logic qs);
    return {regv[1][3:0] & {4{ps}}, regv[4][3:0], regv[3],
      regv[2][4:0] & {5{qs}}, regv[2][6], regv[2][5] & ps,
      regv[5][4] & ps, regv[5][1:0]};
  endfunction

  task automatic watch(input logic [25:0] exp);
    logic [25:0] seen;
    seen = 26'h0;
    mst.hold(40);
    repeat (40)
    begin
      @(posedge ref_clk);
      seen = seen | outs;
    end
    check("running outputs", 32'(seen), 32'(exp));
  endtask

  task automatic chk_freq(input logic [2:0] c);
    mst.hold(10);
    check("code", 32'(freq_code), 32'(c));
    check("cpu rate", 32'(proc_freq_khz), 32'(cpu_t[c]));
    check("mem rate", 32'(mem_freq_khz), 32'(cpu_t[c]));
    check("pci rate", 32'(pci_freq_khz), 32'(pci_t[c]));
    check("gfx rate", 32'(gfx_freq_khz), 32'(gfx_t[c]));
    check("ref rate", 32'(xtal_freq_khz), 32'h37ee);
  endtask

  // Bound on the whole run.
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    logic a;
    void'($urandom(72814));
    regv = '{8'h00, 8'hff, 8'h7f, 8'hff, 8'h0f, 8'h13, 8'h00};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    mst.hold(10);
    rd_regs();
    check("outputs on", 32'(clk_out_oe), 32'h1);
    watch(exp_outs(1'b1, 1'b1));
    chk_freq(3'h0);
    for (int c = 0; c < 8; c++)
    begin
      regv[0] = {1'b0, 3'(c), 4'h8};
      wr_regs(1);
      chk_freq(3'(c));
    end
    repeat (3)
    begin
      for (int i = 1; i < 7; i++)
        regv[i] = 8'($urandom);
      wr_regs(7);
      rd_regs();
      watch(exp_outs(1'b1, 1'b1));
    end
    proc_stop_n <= 1'b0;
    pci_stop_n <= 1'b0;
    watch(exp_outs(1'b0, 1'b0));
    proc_stop_n <= 1'b1;
    watch(exp_outs(1'b1, 1'b0));
    pci_stop_n <= 1'b1;
    regv[0] = 8'h01;
    wr_regs(1);
    mst.hold(10);
    check("outputs off", 32'(clk_out_oe), 32'h0);
    hw_freq_sel <= 3'($urandom);
    regv[0] = 8'h00;
    wr_regs(1);
    check("outputs on", 32'(clk_out_oe), 32'h1);
    chk_freq(hw_freq_sel);
    mst.start();
    mst.wr(8'h54, a);
    check("foreign ack", 32'(a), 32'h1);
    mst.stop();
    rd_regs();
    mst.hold(4);
    end_of_test();
  end
endmodule
`default_nettype wire
